// *** hw/mac_filter_pkg.sv ***
// Constants, types and register map of the station address and group hash filter
package mac_filter_pkg;

    // ========================================================================
    // Register indices (byte address is four times the index)
    localparam logic [2:0] IDX_FILTER_STATUS      = 3'h0;
    localparam logic [2:0] IDX_FILTER_CTRL        = 3'h1;
    localparam logic [2:0] IDX_STATION_ADDR_UPPER = 3'h2;
    localparam logic [2:0] IDX_STATION_ADDR_LOWER = 3'h3;
    localparam logic [2:0] IDX_GROUP_HASH_UPPER   = 3'h4;
    localparam logic [2:0] IDX_GROUP_HASH_LOWER   = 3'h5;

    // ========================================================================
    // Reset values
    localparam logic [15:0] STATION_UPPER_RST = 16'h0fff;
    localparam logic [31:0] STATION_LOWER_RST = 32'h0fff_ffff;
    localparam logic [31:0] GROUP_HASH_RST    = 32'h0000_0000;

    // ========================================================================
    // Field positions
    localparam int CTRL_ACCEPT_ALL_BIT  = 0;
    localparam int STAT_LOAD_DONE_BIT   = 0;
    localparam int STAT_LOADED_BIT      = 1;
    localparam int STAT_HASH_IDX_LSB    = 8;
    localparam int STAT_HASH_IDX_W      = 6;
    localparam int STATION_UPPER_W      = 16;

    // ========================================================================
    // Serial memory layout and address matching
    localparam logic [7:0] MEM_FIRST_LOC = 8'h01;
    localparam logic [7:0] MEM_LAST_LOC  = 8'h06;
    localparam logic [2:0] ADDR_BYTES    = 3'h6;

    // ========================================================================
    // Frame check sequence
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY = 32'hedb8_8320;

    typedef enum logic [3:0] {
        LD_WAIT = 4'b0001,
        LD_REQ  = 4'b0010,
        LD_RSP  = 4'b0100,
        LD_DONE = 4'b1000
    } load_state_e;

    typedef struct packed {
        logic       done;
        logic       station_match;
        logic       is_group;
        logic       group_accept;
        logic [5:0] hash_index;
    } rx_result_s;

endpackage : mac_filter_pkg

// *** hw/mac_address_hash_filter.sv ***
// Station address, group hash table, power-on loader and receive address filter
// ============================================================================
// Functional notes
// - Upper station register keeps address bits 47:32 in bits 15:0; 31:16 read zero.
// - Lower station register keeps address bits 31:0 over its whole width.
// - At power-on load both address registers only if programmed memory is detected.
// - Upper bits 7:0 come from location 0x05, bits 15:8 from 0x06.
// - Lower register filled bytewise from 0x01 (bits 7:0) up to 0x04 (31:24).
// - Lower bits 7:0 match first received byte; upper bits 15:8 the sixth.
// - Address contents are not relied on until the power-on load has finished.
// - Six-bit index: top bit picks table register, low five pick the bit.
// - Index 00000 picks lower bit 0; 11111 with high bit picks upper bit 31.
// - Multicast frame accepted when selected hash bit is 1, rejected when 0.
// - Pass-all-multicast control accepts every multicast frame regardless of table.
// - Hash table is two 32-bit registers: upper 63:32, lower 31:0.
// - Both hash registers clear to zero at reset.
`timescale 1ns/100ps

module mac_address_hash_filter
    import mac_filter_pkg::*;
#(
    parameter int ADR_W = 5
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADR_W-1:0]  adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Serial memory controller
    input  wire logic              mem_ready_i,
    input  wire logic              mem_present_i,
    output logic                   mem_req_o,
    output logic      [7:0]        mem_addr_o,
    input  wire logic              mem_valid_i,
    input  wire logic [7:0]        mem_data_i,
    // Receive destination address bytes
    input  wire logic              rx_start_i,
    input  wire logic              rx_valid_i,
    input  wire logic [7:0]        rx_data_i,
    output rx_result_s             result_o,
    output logic                   load_done_o
);

    // ========================================================================
    // Elaboration check
    if (ADR_W < 5)
    begin : g_bad_adr
        $error("ADR_W must cover six word registers");
    end

    // ========================================================================
    // Declarations
    logic [15:0]       station_upper_q;
    logic [31:0]       station_lower_q;
    logic [31:0]       group_hash_upper_q;
    logic [31:0]       group_hash_lower_q;
    logic              accept_all_group_q;
    logic              ack_q;
    logic [31:0]       dat_q;
    load_state_e       ld_state_q;
    logic [7:0]        ld_addr_q;
    logic              mem_req_q;
    logic              load_done_q;
    logic              loaded_q;
    logic [2:0]        rx_cnt_q;
    logic [31:0]       crc_q;
    logic              match_q;
    logic              group_q;
    rx_result_s        result_q;
    logic [5:0]        last_idx_q;
    logic [ADR_W-3:0]  reg_idx;
    logic              bus_req;
    logic              bus_wr;
    logic [31:0]       rd_mux;
    logic [31:0]       crc_n;
    logic [31:0]       crc_final;
    logic [5:0]        hash_idx;
    logic              hash_bit;
    logic [47:0]       station_all;
    logic [7:0]        station_byte;
    logic              byte_ok;
    logic              first_group;

    // ========================================================================
    // Frame check sequence, one byte, least significant bit first
    function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] data);
        logic [31:0] c;
        c = crc_in;
        for (int b = 0; b < 8; b++)
        begin
            if (c[0] ^ data[b])
            begin
                c = (c >> 1) ^ CRC_POLY;
            end
            else
            begin
                c = c >> 1;
            end
        end
        return c;
    endfunction : crc_byte

    // ========================================================================
    // Bus decode
    assign reg_idx = adr_i[ADR_W-1:2];
    assign bus_req = cyc_i && stb_i;
    // Write lands on the edge where the master sees ack
    assign bus_wr  = bus_req && we_i && ack_q;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            (ADR_W-2)'(IDX_FILTER_STATUS):
            begin
                rd_mux[STAT_LOAD_DONE_BIT] = load_done_q;
                rd_mux[STAT_LOADED_BIT]    = loaded_q;
                rd_mux[STAT_HASH_IDX_LSB +: STAT_HASH_IDX_W] = last_idx_q;
            end
            (ADR_W-2)'(IDX_FILTER_CTRL):        rd_mux[CTRL_ACCEPT_ALL_BIT] = accept_all_group_q;
            (ADR_W-2)'(IDX_STATION_ADDR_UPPER): rd_mux[STATION_UPPER_W-1:0] = station_upper_q;
            (ADR_W-2)'(IDX_STATION_ADDR_LOWER): rd_mux = station_lower_q;
            (ADR_W-2)'(IDX_GROUP_HASH_UPPER):   rd_mux = group_hash_upper_q;
            (ADR_W-2)'(IDX_GROUP_HASH_LOWER):   rd_mux = group_hash_lower_q;
            // Unmapped words answer with zero
            default:                            rd_mux = 32'h0000_0000;
        endcase
    end

    // ========================================================================
    // Bus answer: one ack per request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= bus_req && !ack_q;
            if (bus_req && !ack_q)
            begin
                dat_q <= rd_mux;
            end
        end
    end

    // ========================================================================
    // Control register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            accept_all_group_q <= 1'b0;
        end
        else if (bus_wr && reg_idx == (ADR_W-2)'(IDX_FILTER_CTRL) && sel_i[0])
        begin
            accept_all_group_q <= dat_i[CTRL_ACCEPT_ALL_BIT];
        end
    end

    // ========================================================================
    // Group hash table
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            group_hash_upper_q <= GROUP_HASH_RST;
            group_hash_lower_q <= GROUP_HASH_RST;
        end
        else if (bus_wr)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (sel_i[b] && reg_idx == (ADR_W-2)'(IDX_GROUP_HASH_UPPER))
                begin
                    group_hash_upper_q[8*b +: 8] <= dat_i[8*b +: 8];
                end
                if (sel_i[b] && reg_idx == (ADR_W-2)'(IDX_GROUP_HASH_LOWER))
                begin
                    group_hash_lower_q[8*b +: 8] <= dat_i[8*b +: 8];
                end
            end
        end
    end

    // ========================================================================
    // Power-on loader
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ld_state_q  <= LD_WAIT;
            ld_addr_q   <= MEM_FIRST_LOC;
            mem_req_q   <= 1'b0;
            load_done_q <= 1'b0;
            loaded_q    <= 1'b0;
        end
        else
        begin
            mem_req_q <= 1'b0;
            case (ld_state_q)
                LD_WAIT:
                begin
                    if (mem_ready_i)
                    begin
                        if (mem_present_i)
                        begin
                            ld_state_q <= LD_REQ;
                        end
                        else
                        begin
                            ld_state_q  <= LD_DONE;
                            load_done_q <= 1'b1;
                        end
                    end
                end
                LD_REQ:
                begin
                    mem_req_q  <= 1'b1;
                    ld_state_q <= LD_RSP;
                end
                LD_RSP:
                begin
                    if (mem_valid_i)
                    begin
                        if (ld_addr_q == MEM_LAST_LOC)
                        begin
                            ld_state_q  <= LD_DONE;
                            load_done_q <= 1'b1;
                            loaded_q    <= 1'b1;
                        end
                        else
                        begin
                            ld_addr_q  <= ld_addr_q + 8'h01;
                            ld_state_q <= LD_REQ;
                        end
                    end
                end
                LD_DONE:
                begin
                    ld_state_q <= LD_DONE;
                end
                default:
                begin
                    ld_state_q <= LD_WAIT;
                end
            endcase
        end
    end

    // ========================================================================
    // Station address; host writes held off until the load is over
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            station_upper_q <= STATION_UPPER_RST;
            station_lower_q <= STATION_LOWER_RST;
        end
        else if (ld_state_q == LD_RSP && mem_valid_i)
        begin
            case (ld_addr_q)
                8'h01:   station_lower_q[7:0]   <= mem_data_i;
                8'h02:   station_lower_q[15:8]  <= mem_data_i;
                8'h03:   station_lower_q[23:16] <= mem_data_i;
                8'h04:   station_lower_q[31:24] <= mem_data_i;
                8'h05:   station_upper_q[7:0]   <= mem_data_i;
                8'h06:   station_upper_q[15:8]  <= mem_data_i;
                default: station_upper_q        <= station_upper_q;
            endcase
        end
        else if (bus_wr && load_done_q)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (sel_i[b] && reg_idx == (ADR_W-2)'(IDX_STATION_ADDR_LOWER))
                begin
                    station_lower_q[8*b +: 8] <= dat_i[8*b +: 8];
                end
                if (b < 2 && sel_i[b] && reg_idx == (ADR_W-2)'(IDX_STATION_ADDR_UPPER))
                begin
                    station_upper_q[8*b +: 8] <= dat_i[8*b +: 8];
                end
            end
        end
    end

    // ========================================================================
    // Receive path: CRC, station compare and hash lookup
    assign station_all  = {station_upper_q, station_lower_q};
    assign station_byte = station_all[8*rx_cnt_q +: 8];
    assign byte_ok      = (rx_data_i == station_byte);
    assign first_group  = (rx_cnt_q == 3'h0) ? rx_data_i[0] : group_q;
    assign crc_n        = crc_byte(crc_q, rx_data_i);
    assign crc_final    = ~crc_n;
    assign hash_idx     = crc_final[31:26];
    // Top index bit picks the register, the other five the bit in it
    assign hash_bit     = hash_idx[5] ? group_hash_upper_q[hash_idx[4:0]]
                                      : group_hash_lower_q[hash_idx[4:0]];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_cnt_q   <= 3'h0;
            crc_q      <= CRC_INIT;
            match_q    <= 1'b1;
            group_q    <= 1'b0;
            result_q   <= '0;
            last_idx_q <= 6'h00;
        end
        else
        begin
            result_q.done <= 1'b0;
            if (rx_start_i)
            begin
                rx_cnt_q <= 3'h0;
                crc_q    <= CRC_INIT;
                match_q  <= 1'b1;
                group_q  <= 1'b0;
            end
            else if (rx_valid_i && rx_cnt_q < ADDR_BYTES)
            begin
                rx_cnt_q <= rx_cnt_q + 3'h1;
                crc_q    <= crc_n;
                match_q  <= match_q && byte_ok;
                group_q  <= first_group;
                if (rx_cnt_q == ADDR_BYTES - 3'h1)
                begin
                    result_q.done          <= 1'b1;
                    // Address is undefined until the load ends, so no match before
                    result_q.station_match <= match_q && byte_ok && load_done_q;
                    result_q.is_group      <= first_group;
                    result_q.group_accept  <= first_group && (accept_all_group_q || hash_bit);
                    result_q.hash_index    <= hash_idx;
                    last_idx_q             <= hash_idx;
                end
            end
        end
    end

    // ========================================================================
    // Outputs
    assign dat_o       = dat_q;
    assign ack_o       = ack_q;
    assign mem_req_o   = mem_req_q;
    assign mem_addr_o  = ld_addr_q;
    assign result_o    = result_q;
    assign load_done_o = load_done_q;

endmodule : mac_address_hash_filter

// *** tb/mac_filter_assertions.sv ***
// Port-level checker for the station address and group hash filter
`timescale 1ns/100ps
module mac_filter_assertions
    import mac_filter_pkg::*;
#(
    parameter int ADR_W = 5
)(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic             mem_ready_i,
    input wire logic             mem_present_i,
    input wire logic             mem_req_o,
    input wire logic [7:0]       mem_addr_o,
    input wire logic             mem_valid_i,
    input wire logic [7:0]       mem_data_i,
    input wire logic             rx_start_i,
    input wire logic             rx_valid_i,
    input wire logic [7:0]       rx_data_i,
    input wire rx_result_s       result_o,
    input wire logic             load_done_o
);
    // ========================================================================
    // Properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not a one-cycle ack");
    chk_upper_reserved: assert property (cyc_i && stb_i && !ack_o && !we_i && adr_i[4:2] == 3'h2
        |=> dat_o[31:16] == 16'h0000) else $error("reserved upper bits not zero");
    chk_req_pulse: assert property (mem_req_o |-> mem_addr_o >= 8'h01 && mem_addr_o <= 8'h06 ##1 !mem_req_o)
        else $error("memory request malformed");
    chk_loc_step: assert property (mem_valid_i && mem_addr_o < 8'h06
        |=> mem_addr_o == $past(mem_addr_o) + 8'h01 ##1 mem_req_o) else $error("location order broken");
    chk_load_last: assert property (mem_valid_i && mem_addr_o == 8'h06 |=> load_done_o)
        else $error("load not done after last location");
    chk_absent_skip: assert property (mem_ready_i && !mem_present_i && !load_done_o |=> load_done_o)
        else $error("absent memory did not finish load");
    chk_done_holds: assert property (load_done_o |=> $stable(load_done_o))
        else $error("load done dropped");
    chk_early_match: assert property (!load_done_o |-> !result_o.station_match)
        else $error("match before load done");
    chk_group_only: assert property (result_o.group_accept |-> result_o.is_group)
        else $error("non-group frame accepted as group");
    chk_result_pulse: assert property (result_o.done |=> !result_o.done)
        else $error("result done not a pulse");
endmodule : mac_filter_assertions

bind mac_address_hash_filter mac_filter_assertions #(.ADR_W(ADR_W)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mem_ready_i(mem_ready_i),
    .mem_present_i(mem_present_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
    .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .rx_start_i(rx_start_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .result_o(result_o), .load_done_o(load_done_o)
);

// *** tb/serial_mem_model.sv ***
// Serial memory controller stand-in: detection, then one byte per request
`timescale 1ns/100ps
module serial_mem_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       present_i,
    input  wire logic       slow_i,
    input  wire logic       req_i,
    input  wire logic [7:0] addr_i,
    output logic            ready_o,
    output logic            present_o,
    output logic            valid_o,
    output logic [7:0]      data_o
);
    // ========================================================================
    // Detection and read answers
    logic [3:0] det_q;
    logic [3:0] wait_q;
    logic       busy_q;
    logic [7:0] loc_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            det_q <= 4'h0;
            busy_q <= 1'b0;
            valid_o <= 1'b0;
            wait_q <= 4'h0;
            loc_q <= 8'h00;
            data_o <= 8'h5a;
        end
        else
        begin
            if (det_q != 4'h8)
                det_q <= det_q + 4'h1;
            valid_o <= 1'b0;
            // Idle lines toggle so a stale byte is never taken as data
            data_o <= ~data_o;
            if (req_i)
            begin
                busy_q <= 1'b1;
                loc_q <= addr_i;
                wait_q <= slow_i ? 4'h6 : 4'h0;
            end
            else if (busy_q && wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
            else if (busy_q)
            begin
                busy_q <= 1'b0;
                valid_o <= 1'b1;
                data_o <= 8'ha0 + loc_q;
            end
        end
    end

    assign ready_o = (det_q == 4'h8);
    assign present_o = ready_o & present_i;
endmodule : serial_mem_model

// *** tb/mac_address_hash_filter_tb_top.sv ***
// Self-checking bench for the station address and group hash filter
`timescale 1ns/100ps
module mac_address_hash_filter_tb_top
    import mac_filter_pkg::*;
;
    // ========================================================================
    // Signals
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [4:0] adr_i = 0;
    logic [3:0] sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, rd;
    logic ack_o, mready, mpres, mreq, mvalid, load_done_o, pres = 1, slow = 0;
    logic [7:0] maddr, mdata, rx_data_i = 0;
    logic rx_start_i = 0, rx_valid_i = 0, acc_all = 0, ld_ok = 0;
    logic [1:0] ends = 0;
    logic [47:0] station, a;
    logic [63:0] tbl = 0;
    logic [5:0] ix;
    rx_result_s result_o;
    int error_cnt = 0, checks = 0, cycles = 0;

    mac_address_hash_filter #(.ADR_W(5)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mem_ready_i(mready),
        .mem_present_i(mpres), .mem_req_o(mreq), .mem_addr_o(maddr), .mem_valid_i(mvalid),
        .mem_data_i(mdata), .rx_start_i(rx_start_i), .rx_valid_i(rx_valid_i),
        .rx_data_i(rx_data_i), .result_o(result_o), .load_done_o(load_done_o));
    serial_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .present_i(pres), .slow_i(slow),
        .req_i(mreq), .addr_i(maddr), .ready_o(mready), .present_o(mpres), .valid_o(mvalid), .data_o(mdata));

    always #2.5 clk_i = ~clk_i;

    // ========================================================================
    // Report and compares
    task automatic final_report;
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // Bound covers every load, frame and bus wait of the sequence
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            $display("ERROR %0t timeout", $time);
            final_report;
        end
    end

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t reg %h exp %h", $time, got, exp);
        end
    endtask : cmp32

    task automatic cmp_res(input rx_result_s got, input rx_result_s exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t result %h exp %h", $time, got, exp);
        end
    endtask : cmp_res

    // ========================================================================
    // Wishbone classic cycles and receive frames
    task automatic wb(input logic w, input logic [2:0] ix3, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= {ix3, 2'b00};
        sel_i <= 4'hf;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
    endtask : wb

    task automatic chk_rd(input logic [2:0] ix3, input logic [31:0] exp);
        wb(0, ix3, 32'h0000_0000);
        cmp32(rd, exp);
    endtask : chk_rd

    task automatic set_tbl(input logic [63:0] t);
        tbl = t;
        wb(1, 3'h4, t[63:32]);
        wb(1, 3'h5, t[31:0]);
    endtask : set_tbl

    function automatic logic [5:0] hidx(input logic [47:0] v);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ v[i]) ? CRC_POLY : 32'h0000_0000);
        return ~c[31:26];
    endfunction : hidx

    // Byte k of the address goes out k-th, low byte first
    task automatic frame(input logic [47:0] v);
        rx_result_s e;
        int n;
        e = '{1'b1, (v == station) && ld_ok, v[0], v[0] & (acc_all | tbl[hidx(v)]), hidx(v)};
        @(posedge clk_i);
        rx_start_i <= 1;
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk_i);
            rx_start_i <= 0;
            rx_valid_i <= 1;
            rx_data_i <= v[8*k +: 8];
        end
        @(posedge clk_i);
        rx_valid_i <= 0;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (result_o.done !== 1'b1 && n < 4);
        cmp_res(result_o, e);
    endtask : frame

    task automatic restart(input logic p, input logic s);
        @(posedge clk_i);
        pres <= p;
        slow <= s;
        rst_i <= 1;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        tbl = 0;
        acc_all = 0;
        ld_ok = 0;
    endtask : restart

    task automatic wait_load;
        while (load_done_o !== 1'b1)
            @(posedge clk_i);
        ld_ok = 1;
    endtask : wait_load

    // ========================================================================
    // Sequence
    initial
    begin
        restart(1, 0);
        wait_load;
        chk_rd(3'h4, 32'h0000_0000);
        chk_rd(3'h5, 32'h0000_0000);
        chk_rd(3'h2, 32'h0000_a6a5);
        chk_rd(3'h3, 32'ha4a3_a2a1);
        station = 48'ha6a5_a4a3_a2a1;
        frame(station);
        frame(station ^ 48'h8000_0000_0000);
        wb(1, 3'h2, 32'hffff_6677);
        chk_rd(3'h2, 32'h0000_6677);
        wb(1, 3'h3, 32'h5544_3301);
        station = 48'h6677_5544_3301;
        frame(station);
        chk_rd(3'h6, 32'h0000_0000);
        // Scan all 4096 values, acting on the first two and on the first hits of both ends of the index range
        for (int b = 0; b < 4096; b++)
        begin
            a = {b[11:0], 28'h000_0000, 8'h01};
            ix = hidx(a);
            if (b < 2 || (ix == 6'h00 && !ends[0]) || (ix == 6'h3f && !ends[1]))
            begin
                ends = ends | {ix == 6'h3f, ix == 6'h00};
                set_tbl(64'h1 << ix);
                frame(a);
                set_tbl(~(64'h1 << ix));
                frame(a);
            end
        end
        cmp32({30'h0000_0000, ends}, 32'h0000_0003);
        set_tbl(64'h0);
        wb(1, 3'h1, 32'h0000_0001);
        chk_rd(3'h1, 32'h0000_0001);
        acc_all = 1;
        frame(a);
        frame(48'h0000_0000_0002);
        restart(0, 0);
        wait_load;
        chk_rd(3'h2, 32'h0000_0fff);
        chk_rd(3'h3, 32'h0fff_ffff);
        station = 48'h0fff_0fff_ffff;
        frame(station);
        chk_rd(3'h0, (32'(hidx(station)) << STAT_HASH_IDX_LSB) | 32'h0000_0001);
        restart(1, 1);
        frame(station);
        wait_load;
        chk_rd(3'h3, 32'ha4a3_a2a1);
        chk_rd(3'h0, (32'(hidx(station)) << STAT_HASH_IDX_LSB) | 32'h0000_0003);
        final_report;
    end
endmodule : mac_address_hash_filter_tb_top
